// ===== rtl/ebrf_block_ram.sv
// ebrf_block_ram: 9-kbit block ram with ram, rom and fifo modes, apb config.
// assumes side clocks, gates and strobes are synchronous levels on sys_clk;
// a side clock's rising edge, seen on sys_clk, is the port's active edge.
//
// Contract
// [R1] 9-kbit array with registers at its inputs and its outputs.
// [R2] single, true dual, pseudo dual and fifo use; widths x1 to x36.
// [R3] each port chooses its own width and depth; fifo mode runs both ports at port a width.
// [R4] word 0 lsb to msb, then word 1, same for every port width.
// [R5] contents preloadable; with writes locked the block acts as rom.
// [R6] address and write data captured in input registers at the edge.
// [R7] optional output register adds one port cycle of latency.
// [R8] normal write mode: output holds its value during a write.
// [R9] write-through: written data appears on the same port, all widths.
// [R10] read-before-write shows old contents; only x9, x18, x36.
// [R11] fifo writes on port a side, reads on port b side.
// [R12] full and near-full flags registered on the write side clock.
// [R13] empty and near-empty flags registered on the read side clock.
// [R14] programmable full, near-full, near-empty thresholds; empty at zero.
// [R15] port a clear resets both pointers and all fifo flags.
// [R16] port b clear resets only the read pointer for retransmit.
// [R17] port clears and chip-wide clear reset the output latches asynchronously.
// [R18] user holds clock enables low one cycle around an async reset.
// [R19] with enables active, reset only after clocks steady one period.
// [R20] preloaded block: global clear disabled or released before io active.
// [R21] fifo: global clear always on; strobes act as clock enables.
// [R22] synchronous clear with global clear disabled has no sequencing limits.
// [R23] write ignored while full, read ignored while empty.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ebrf_block_ram #(
  parameter logic [ebrf_pkg::BIT_CAP-1:0] INIT_BITS = '0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chipWideClearN,
  input wire logic portAClear,
  input wire logic portBClear,
  input wire logic aSideClock,
  input wire logic aClockGate,
  input wire logic aStrobe,
  input wire logic [ebrf_pkg::ADDR_W-1:0] aAddr,
  input wire logic [ebrf_pkg::DATA_W-1:0] aWdata,
  output logic [ebrf_pkg::DATA_W-1:0] aRdata,
  input wire logic bSideClock,
  input wire logic bClockGate,
  input wire logic bStrobe,
  input wire logic [ebrf_pkg::ADDR_W-1:0] bAddr,
  input wire logic [ebrf_pkg::DATA_W-1:0] bWdata,
  output logic [ebrf_pkg::DATA_W-1:0] bRdata,
  output logic fullFlag,
  output logic nearFullFlag,
  output logic emptyFlag,
  output logic nearEmptyFlag
);
  localparam int DW = ebrf_pkg::DATA_W;
  localparam int AW = ebrf_pkg::ADDR_W;
  localparam int TW = ebrf_pkg::TH_W;
  localparam int NW = ebrf_pkg::TOT_W;

  function automatic logic [5:0] widthOf(input logic [2:0] sel);
    unique case (sel)
      ebrf_pkg::WSEL_X1: widthOf = 6'h01;
      ebrf_pkg::WSEL_X2: widthOf = 6'h02;
      ebrf_pkg::WSEL_X4: widthOf = 6'h04;
      ebrf_pkg::WSEL_X9: widthOf = 6'h09;
      ebrf_pkg::WSEL_X18: widthOf = 6'h12;
      default: widthOf = 6'h24;
    endcase
  endfunction

  // x1/x2/x4 see 8192 bits, the parity widths the full 9216
  function automatic logic [TW-1:0] depthOf(input logic [2:0] sel);
    unique case (sel)
      ebrf_pkg::WSEL_X1: depthOf = 14'h2000;
      ebrf_pkg::WSEL_X2: depthOf = 14'h1000;
      ebrf_pkg::WSEL_X4: depthOf = 14'h0800;
      ebrf_pkg::WSEL_X9: depthOf = 14'h0400;
      ebrf_pkg::WSEL_X18: depthOf = 14'h0200;
      default: depthOf = 14'h0100;
    endcase
  endfunction

  function automatic logic [DW-1:0] maskOf(input logic [5:0] w);
    maskOf = '0;
    for (int i = 0; i < DW; i++)
    begin
      maskOf[i] = (i < int'(w));
    end
  endfunction

  function automatic logic parityWidth(input logic [2:0] sel);
    parityWidth = (sel == ebrf_pkg::WSEL_X9) || (sel == ebrf_pkg::WSEL_X18) || (sel == ebrf_pkg::WSEL_X36);
  endfunction

  // ---------------- apb register file ----------------
  logic [31:0] ctrl_q;
  logic [TW-1:0] fullTh_q;
  logic [TW-1:0] nearFullTh_q;
  logic [TW-1:0] nearEmptyTh_q;
  logic [1:0] syncClr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdValue;
  logic addrHit;
  logic apbWrite;
  logic cfgErr;
  logic [TW-1:0] fill;
  ebrf_pkg::ebrf_flags_t flags_q;
  logic full_q, nearFull_q, empty_q, nearEmpty_q;

  assign apbWrite = psel && penable && pwrite;
  assign addrHit = (paddr == ebrf_pkg::REG_CTRL) || (paddr == ebrf_pkg::REG_FULL_TH) ||
                   (paddr == ebrf_pkg::REG_NEAR_FULL_TH) || (paddr == ebrf_pkg::REG_NEAR_EMPTY_TH) ||
                   (paddr == ebrf_pkg::REG_STATUS);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= ebrf_pkg::CTRL_RESET;
      fullTh_q <= ebrf_pkg::FULL_TH_RESET;
      nearFullTh_q <= ebrf_pkg::NEAR_FULL_TH_RESET;
      nearEmptyTh_q <= ebrf_pkg::NEAR_EMPTY_TH_RESET;
    end
    else if (apbWrite)
    begin
      // sync clear bits are pulses, never stored
      if (paddr == ebrf_pkg::REG_CTRL)
        ctrl_q <= {14'h0000, 2'b00, pwdata[15:0]};
      if (paddr == ebrf_pkg::REG_FULL_TH)
        fullTh_q <= pwdata[TW-1:0];
      if (paddr == ebrf_pkg::REG_NEAR_FULL_TH)
        nearFullTh_q <= pwdata[TW-1:0];
      if (paddr == ebrf_pkg::REG_NEAR_EMPTY_TH)
        nearEmptyTh_q <= pwdata[TW-1:0];
    end
  end

  // [R22] synchronous clear path
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      syncClr_q <= 2'b00;
    else
      syncClr_q <= (apbWrite && paddr == ebrf_pkg::REG_CTRL) ?
                   {pwdata[ebrf_pkg::CTRL_SYNC_CLR_B_POS], pwdata[ebrf_pkg::CTRL_SYNC_CLR_A_POS]} : 2'b00;
  end

  always_comb
  begin
    rdValue = 32'h0000_0000;
    if (paddr == ebrf_pkg::REG_CTRL)
      rdValue = ctrl_q;
    else if (paddr == ebrf_pkg::REG_FULL_TH)
      rdValue = {18'h00000, fullTh_q};
    else if (paddr == ebrf_pkg::REG_NEAR_FULL_TH)
      rdValue = {18'h00000, nearFullTh_q};
    else if (paddr == ebrf_pkg::REG_NEAR_EMPTY_TH)
      rdValue = {18'h00000, nearEmptyTh_q};
    else if (paddr == ebrf_pkg::REG_STATUS)
    begin
      rdValue[ebrf_pkg::STAT_FLAGS_POS +: 4] = flags_q;
      rdValue[ebrf_pkg::STAT_CFG_ERR_POS] = cfgErr;
      rdValue[ebrf_pkg::STAT_FILL_POS +: TW] = fill;
    end
  end

  // read data latched in the setup cycle, so the access never waits
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_q <= rdValue;
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit;

  // ---------------- configuration decode ----------------
  ebrf_pkg::ebrf_mode_t mode;
  ebrf_pkg::ebrf_wrmode_t wrMode [2];
  logic [2:0] widthSel [2];
  logic [5:0] width [2];
  logic [1:0] outRegEn;
  logic isFifo;
  logic romLock;
  logic globalClr;

  assign mode = ebrf_pkg::ebrf_mode_t'(ctrl_q[ebrf_pkg::CTRL_MODE_POS +: 2]);
  assign isFifo = (mode == ebrf_pkg::MODE_FIFO);
  assign wrMode[0] = ebrf_pkg::ebrf_wrmode_t'(ctrl_q[ebrf_pkg::CTRL_WRMODE_A_POS +: 2]);
  assign wrMode[1] = ebrf_pkg::ebrf_wrmode_t'(ctrl_q[ebrf_pkg::CTRL_WRMODE_B_POS +: 2]);
  assign outRegEn = {ctrl_q[ebrf_pkg::CTRL_OUTREG_B_POS], ctrl_q[ebrf_pkg::CTRL_OUTREG_A_POS]};
  // [R3] independent widths; fifo runs both sides at port a width
  assign widthSel[0] = ctrl_q[ebrf_pkg::CTRL_WIDTH_A_POS +: 3];
  assign widthSel[1] = isFifo ? widthSel[0] : ctrl_q[ebrf_pkg::CTRL_WIDTH_B_POS +: 3];
  assign width[0] = widthOf(widthSel[0]);
  assign width[1] = widthOf(widthSel[1]);
  // [R5] write lock turns preloaded contents into a rom
  assign romLock = ctrl_q[ebrf_pkg::CTRL_ROM_POS];
  // [R21] fifo keeps the global clear enabled regardless of the control bit
  assign globalClr = !chipWideClearN && (ctrl_q[ebrf_pkg::CTRL_GLOBAL_EN_POS] || isFifo);

  // [R2] true dual port tops out at x18; flagged, not enforced
  assign cfgErr = ((mode == ebrf_pkg::MODE_TRUE_DUAL) &&
                   (widthSel[0] > ebrf_pkg::WSEL_X18 || widthSel[1] > ebrf_pkg::WSEL_X18)) ||
                  (widthSel[0] > ebrf_pkg::WSEL_X36) || (widthSel[1] > ebrf_pkg::WSEL_X36);

  // ---------------- side clock edges ----------------
  logic [1:0] sideClk;
  logic [1:0] sideClkPrev_q;
  logic [1:0] sideEdge;
  logic [1:0] gate;
  logic [1:0] strobe;

  assign sideClk = {bSideClock, aSideClock};
  assign gate = {bClockGate, aClockGate};
  assign strobe = {bStrobe, aStrobe};
  assign sideEdge = sideClk & ~sideClkPrev_q;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      sideClkPrev_q <= 2'b00;
    else
      sideClkPrev_q <= sideClk;
  end

  // ---------------- fifo pointers and flags ----------------
  logic fifoRstN;
  logic rdPtrRstN;
  logic fifoWr;
  logic fifoRd;
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [NW-1:0] wrTotal_q;
  logic [NW-1:0] rdTotal_q;
  logic [NW-1:0] diff;
  logic [TW-1:0] depth;

  // [R15] port a clear and the global clear empty the fifo
  assign fifoRstN = rstn && !portAClear && !globalClr;
  // [R16] port b clear rewinds only the read side
  assign rdPtrRstN = fifoRstN && !portBClear;

  assign depth = depthOf(widthSel[0]);
  // retransmit counts from the write total; exact only until the first wrap
  assign diff = wrTotal_q - rdTotal_q;
  assign fill = (diff > NW'(depth)) ? depth : diff[TW-1:0];

  // [R23] hard stop at capacity as well, so a stale flag cannot overwrite
  assign fifoWr = isFifo && sideEdge[0] && gate[0] && strobe[0] && !flags_q.full && (fill != depth);
  assign fifoRd = isFifo && sideEdge[1] && gate[1] && strobe[1] && !flags_q.empty && (fill != '0);

  always_ff @(posedge sys_clk or negedge fifoRstN)
  begin
    if (!fifoRstN)
    begin
      wrPtr_q <= '0;
      wrTotal_q <= '0;
    end
    else if (syncClr_q[0])
    begin
      wrPtr_q <= '0;
      wrTotal_q <= '0;
    end
    else if (fifoWr)
    begin
      wrPtr_q <= (TW'(wrPtr_q) == depth - 14'h0001) ? '0 : wrPtr_q + 13'h0001;
      wrTotal_q <= wrTotal_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rdPtrRstN)
  begin
    if (!rdPtrRstN)
    begin
      rdPtr_q <= '0;
      rdTotal_q <= '0;
    end
    else if (syncClr_q[0] || syncClr_q[1])
    begin
      rdPtr_q <= '0;
      rdTotal_q <= '0;
    end
    else if (fifoRd)
    begin
      rdPtr_q <= (TW'(rdPtr_q) == depth - 14'h0001) ? '0 : rdPtr_q + 13'h0001;
      rdTotal_q <= rdTotal_q + 16'h0001;
    end
  end

  // [R12] write side flags move only on write side clock edges
  always_ff @(posedge sys_clk or negedge fifoRstN)
  begin
    if (!fifoRstN)
    begin
      full_q <= 1'b0;
      nearFull_q <= 1'b0;
    end
    else if (syncClr_q[0])
    begin
      full_q <= 1'b0;
      nearFull_q <= 1'b0;
    end
    else if (sideEdge[0])
    begin
      // [R14] programmable full and near-full thresholds
      full_q <= (fill >= fullTh_q);
      nearFull_q <= (fill >= nearFullTh_q);
    end
  end

  // [R13] read side flags move only on read side clock edges
  always_ff @(posedge sys_clk or negedge fifoRstN)
  begin
    if (!fifoRstN)
    begin
      empty_q <= 1'b1;
      nearEmpty_q <= 1'b1;
    end
    else if (syncClr_q[0])
    begin
      empty_q <= 1'b1;
      nearEmpty_q <= 1'b1;
    end
    else if (sideEdge[1])
    begin
      // [R14] empty threshold fixed at zero
      empty_q <= (fill == '0);
      nearEmpty_q <= (fill <= nearEmptyTh_q);
    end
  end

  assign flags_q = {full_q, nearFull_q, empty_q, nearEmpty_q};
  assign fullFlag = flags_q.full;
  assign nearFullFlag = flags_q.nearFull;
  assign emptyFlag = flags_q.empty;
  assign nearEmptyFlag = flags_q.nearEmpty;

  // ---------------- port request decode ----------------
  ebrf_pkg::ebrf_req_t reqNext [2];
  ebrf_pkg::ebrf_req_t req_q [2];
  logic [DW-1:0] memRdata [2];
  logic [1:0] portClr;

  assign portClr = {portBClear, portAClear};

  // [R11] fifo: port a is the write side, port b the read side
  always_comb
  begin
    reqNext[0] = '{op: 1'b0, we: 1'b0, addr: aAddr, wdata: aWdata};
    reqNext[1] = '{op: 1'b0, we: 1'b0, addr: bAddr, wdata: bWdata};
    if (isFifo)
    begin
      reqNext[0].op = fifoWr;
      reqNext[0].we = 1'b1;
      reqNext[0].addr = wrPtr_q;
      reqNext[1].op = fifoRd;
      reqNext[1].addr = rdPtr_q;
    end
    else
    begin
      // [R2] single port leaves b idle; pseudo dual writes a, reads b
      reqNext[0].op = sideEdge[0] && gate[0] && (mode != ebrf_pkg::MODE_PSEUDO_DUAL || strobe[0]);
      reqNext[0].we = strobe[0] && !romLock;
      reqNext[1].op = sideEdge[1] && gate[1] && (mode != ebrf_pkg::MODE_SINGLE);
      reqNext[1].we = strobe[1] && !romLock && (mode == ebrf_pkg::MODE_TRUE_DUAL);
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      logic latRstN;
      logic rdValid_q;
      logic wasWrite_q;
      logic [DW-1:0] wdataD_q;
      logic [DW-1:0] latch_q;
      logic [DW-1:0] outReg_q;

      // [R17] own port clear or the global clear, asynchronous
      assign latRstN = rstn && !portClr[p] && !globalClr;

      // [R6] input registers at the array
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          req_q[p] <= '0;
        else
          req_q[p] <= reqNext[p];
      end

      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          rdValid_q <= 1'b0;
          wasWrite_q <= 1'b0;
          wdataD_q <= '0;
        end
        else
        begin
          rdValid_q <= req_q[p].op;
          wasWrite_q <= req_q[p].we;
          wdataD_q <= req_q[p].wdata & maskOf(width[p]);
        end
      end

      always_ff @(posedge sys_clk or negedge latRstN)
      begin
        if (!latRstN)
          latch_q <= '0;
        else if (syncClr_q[p])
          latch_q <= '0;
        else if (rdValid_q && !wasWrite_q)
          latch_q <= memRdata[p];
        else if (rdValid_q)
        begin
          unique case (wrMode[p])
            // [R8] normal write leaves the output alone
            ebrf_pkg::WR_NORMAL: latch_q <= latch_q;
            // [R9] write-through for every width
            ebrf_pkg::WR_THROUGH: latch_q <= wdataD_q;
            // [R10] old contents, parity widths only; others behave as normal
            ebrf_pkg::WR_READ_FIRST: latch_q <= parityWidth(widthSel[p]) ? memRdata[p] : latch_q;
            default: latch_q <= latch_q;
          endcase
        end
      end

      // [R7] optional output stage clocked by the next gated side edge
      always_ff @(posedge sys_clk or negedge latRstN)
      begin
        if (!latRstN)
          outReg_q <= '0;
        else if (syncClr_q[p])
          outReg_q <= '0;
        else if (sideEdge[p] && gate[p])
          outReg_q <= latch_q;
      end
    end
  endgenerate

  assign aRdata = outRegEn[0] ? g_port[0].outReg_q : g_port[0].latch_q;
  assign bRdata = outRegEn[1] ? g_port[1].outReg_q : g_port[1].latch_q;

  // [R1] [R4] 9-kbit array, words packed lsb first at addr times width
  ebrf_bit_ram #(
    .BITS(ebrf_pkg::BIT_CAP),
    .INIT_BITS(INIT_BITS)
  ) u_array (
    .sys_clk(sys_clk),
    .aEn(req_q[0].op),
    .aWe(req_q[0].we),
    .aBase(ebrf_pkg::BASE_W'(req_q[0].addr) * ebrf_pkg::BASE_W'(width[0])),
    .aWidth(width[0]),
    .aWdata(req_q[0].wdata),
    .aRdata(memRdata[0]),
    .bEn(req_q[1].op),
    .bWe(req_q[1].we),
    .bBase(ebrf_pkg::BASE_W'(req_q[1].addr) * ebrf_pkg::BASE_W'(width[1])),
    .bWidth(width[1]),
    .bWdata(req_q[1].wdata),
    .bRdata(memRdata[1])
  );
endmodule
`default_nettype wire

// ===== rtl/ebrf_pkg.sv
// ebrf_pkg: constants, types and register map of the embedded block ram / fifo.
// assumes a 32-bit apb master on sys_clk; user ports sampled on sys_clk.
package ebrf_pkg;

  localparam int BIT_CAP = 9216;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 36;
  localparam int BASE_W = 19;
  localparam int TH_W = 14;
  localparam int TOT_W = 16;

  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_FULL_TH = 12'h004;
  localparam logic [11:0] REG_NEAR_FULL_TH = 12'h008;
  localparam logic [11:0] REG_NEAR_EMPTY_TH = 12'h00c;
  localparam logic [11:0] REG_STATUS = 12'h010;

  // control register fields
  localparam int CTRL_MODE_POS = 0;
  localparam int CTRL_WRMODE_A_POS = 2;
  localparam int CTRL_WRMODE_B_POS = 4;
  localparam int CTRL_OUTREG_A_POS = 6;
  localparam int CTRL_OUTREG_B_POS = 7;
  localparam int CTRL_WIDTH_A_POS = 8;
  localparam int CTRL_WIDTH_B_POS = 11;
  localparam int CTRL_ROM_POS = 14;
  localparam int CTRL_GLOBAL_EN_POS = 15;
  localparam int CTRL_SYNC_CLR_A_POS = 16;
  localparam int CTRL_SYNC_CLR_B_POS = 17;
  localparam logic [31:0] CTRL_RESET = 32'h0000_8000;

  // status register fields
  localparam int STAT_FLAGS_POS = 0;
  localparam int STAT_CFG_ERR_POS = 4;
  localparam int STAT_FILL_POS = 8;

  localparam logic [TH_W-1:0] FULL_TH_RESET = 14'h00ff;
  localparam logic [TH_W-1:0] NEAR_FULL_TH_RESET = 14'h00f0;
  localparam logic [TH_W-1:0] NEAR_EMPTY_TH_RESET = 14'h0010;

  // width select codes
  localparam logic [2:0] WSEL_X1 = 3'h0;
  localparam logic [2:0] WSEL_X2 = 3'h1;
  localparam logic [2:0] WSEL_X4 = 3'h2;
  localparam logic [2:0] WSEL_X9 = 3'h3;
  localparam logic [2:0] WSEL_X18 = 3'h4;
  localparam logic [2:0] WSEL_X36 = 3'h5;

  typedef enum logic [1:0] {MODE_SINGLE, MODE_TRUE_DUAL, MODE_PSEUDO_DUAL, MODE_FIFO} ebrf_mode_t;
  typedef enum logic [1:0] {WR_NORMAL, WR_THROUGH, WR_READ_FIRST} ebrf_wrmode_t;

  typedef struct packed {
    logic op;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebrf_req_t;

  typedef struct packed {
    logic full;
    logic nearFull;
    logic empty;
    logic nearEmpty;
  } ebrf_flags_t;

endpackage

// ===== rtl/ebrf_bit_ram.sv
// ebrf_bit_ram: bit-addressed two-port storage array, registered read data.
// assumes each port gives a bit base and width per access; port a wins a clash.
`timescale 1ns/1ns
`default_nettype none
module ebrf_bit_ram #(
  parameter int BITS = ebrf_pkg::BIT_CAP,
  parameter logic [BITS-1:0] INIT_BITS = '0
) (
  input wire logic sys_clk,
  input wire logic aEn,
  input wire logic aWe,
  input wire logic [ebrf_pkg::BASE_W-1:0] aBase,
  input wire logic [5:0] aWidth,
  input wire logic [ebrf_pkg::DATA_W-1:0] aWdata,
  output logic [ebrf_pkg::DATA_W-1:0] aRdata,
  input wire logic bEn,
  input wire logic bWe,
  input wire logic [ebrf_pkg::BASE_W-1:0] bBase,
  input wire logic [5:0] bWidth,
  input wire logic [ebrf_pkg::DATA_W-1:0] bWdata,
  output logic [ebrf_pkg::DATA_W-1:0] bRdata
);
  logic mem [BITS];

  // contents preloaded at configuration, no reset
  initial
  begin
    for (int k = 0; k < BITS; k++)
    begin
      mem[k] = INIT_BITS[k];
    end
  end

  // word k spans bits k*w .. k*w+w-1, lsb first, for every width
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < ebrf_pkg::DATA_W; i++)
    begin
      if (bEn && bWe && (i < int'(bWidth)) && (int'(bBase) + i < BITS))
        mem[int'(bBase) + i] <= bWdata[i];
      if (aEn && aWe && (i < int'(aWidth)) && (int'(aBase) + i < BITS))
        mem[int'(aBase) + i] <= aWdata[i];
    end
  end

  // read returns the old contents, so read-first falls out for free
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < ebrf_pkg::DATA_W; i++)
    begin
      if (aEn)
        aRdata[i] <= ((i < int'(aWidth)) && (int'(aBase) + i < BITS)) ? mem[int'(aBase) + i] : 1'b0;
      if (bEn)
        bRdata[i] <= ((i < int'(bWidth)) && (int'(bBase) + i < BITS)) ? mem[int'(bBase) + i] : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/ebrf_monitor.sv
// ebrf_monitor: port assertions for the block ram and fifo.
// assumes bind to ebrf_block_ram with no output register in use.
`timescale 1ns/1ns
`default_nettype none
module ebrf_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic chipWideClearN,
  input wire logic portAClear,
  input wire logic portBClear,
  input wire logic aSideClock,
  input wire logic bSideClock,
  input wire logic [ebrf_pkg::DATA_W-1:0] aRdata,
  input wire logic [ebrf_pkg::DATA_W-1:0] bRdata,
  input wire logic fullFlag,
  input wire logic emptyFlag,
  input wire logic nearEmptyFlag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  slverr_map_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("no slverr on unmapped");
  full_hold_a: assert property ($past(aSideClock) == $past(aSideClock, 2)
    && $past(aSideClock, 2) == $past(aSideClock, 3) && !portAClear && chipWideClearN |-> $stable(fullFlag))
    else $error("full moved without edge");
  empty_hold_a: assert property ($past(bSideClock) == $past(bSideClock, 2)
    && $past(bSideClock, 2) == $past(bSideClock, 3) && !portAClear
    && !portBClear && chipWideClearN |-> $stable(emptyFlag))
    else $error("empty moved without edge");
  fifo_clear_a: assert property (portAClear |-> !fullFlag && emptyFlag && nearEmptyFlag)
    else $error("flags not cleared");
  a_clear_a: assert property (portAClear |-> aRdata == '0) else $error("a latch kept");
  b_clear_a: assert property (portBClear |-> bRdata == '0) else $error("b latch kept");
  both_clear_a: assert property (!chipWideClearN |-> aRdata == '0 && bRdata == '0)
    else $error("latches kept");
  read_lat_a: assert property ($changed(aRdata) && !portAClear && chipWideClearN
    |-> $past(aSideClock, 3) && !$past(aSideClock, 4)) else $error("a data off time");
  cover property ($rose(fullFlag));
  cover property ($rose(emptyFlag));
  cover property (pslverr);
endmodule
`default_nettype wire

// ===== sim/ebrf_fabric_port.sv
// ebrf_fabric_port: user fabric logic driving one port of the block ram.
// assumes sys_clk is the fabric clock; the bench calls hit.
`timescale 1ns/1ns
`default_nettype none
module ebrf_fabric_port (
  input wire logic sys_clk,
  output logic sideClock,
  output logic gate,
  output logic strobe,
  output logic [ebrf_pkg::ADDR_W-1:0] addr,
  output logic [ebrf_pkg::DATA_W-1:0] wdata
);
  int n = 0;
  initial
  begin
    {sideClock, gate, strobe} = 3'h0;
    addr = '0;
    wdata = '0;
  end
  task automatic hit(input logic [1:0] gs, input logic [12:0] ad, input logic [35:0] d);
    @(posedge sys_clk);
    {sideClock, gate, strobe} <= {1'h1, gs};
    addr <= ad;
    wdata <= d;
    repeat (2) @(posedge sys_clk);
    {sideClock, gate, strobe} <= 3'h0;
    // released lines carry junk, never stale data
    addr <= ~ad;
    wdata <= ~d;
    n++;
    repeat (2 + n % 3) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// tb_top: self-checking bench of the block ram in ram and fifo modes.
// assumes package, fabric port model and monitor compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic sys_clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic chipWideClearN = 1'h1;
  logic portAClear = 1'h0;
  logic portBClear = 1'h0;
  logic aSideClock, aClockGate, aStrobe, bSideClock, bClockGate, bStrobe;
  logic fullFlag, nearFullFlag, emptyFlag, nearEmptyFlag;
  logic [ebrf_pkg::ADDR_W-1:0] aAddr, bAddr;
  logic [ebrf_pkg::DATA_W-1:0] aWdata, bWdata, aRdata, bRdata, d, o;
  logic [ebrf_pkg::DATA_W-1:0] wd [4];
  logic [31:0] rstv [6] = '{32'h8000, 32'hff, 32'hf0, 32'h10, 32'h3, 32'h0};
  logic [15:0] lf = 16'h005f;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  always #4 sys_clk = ~sys_clk;
  ebrf_block_ram dut_u (.*);
  ebrf_fabric_port pa (.sys_clk, .sideClock(aSideClock), .gate(aClockGate), .strobe(aStrobe),
    .addr(aAddr), .wdata(aWdata));
  ebrf_fabric_port pb (.sys_clk, .sideClock(bSideClock), .gate(bClockGate), .strobe(bStrobe),
    .addr(bAddr), .wdata(bWdata));
  function automatic logic [35:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return {lf[3:0], lf, ~lf};
  endfunction
  // output during a write: 0 normal, 1 through, 2 old data
  function automatic logic [35:0] wr_view(input int m, input logic [35:0] old, input logic [35:0] nw);
    return m == 1 ? nw : (m == 2 ? old : 36'h0);
  endfunction
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1)
      @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // clears only while enables and side clocks rest
  task automatic clr(input logic [2:0] m);
    repeat (2) @(posedge sys_clk);
    {chipWideClearN, portBClear, portAClear} <= m ^ 3'h4;
    repeat (2) @(posedge sys_clk);
    {chipWideClearN, portBClear, portAClear} <= 3'h4;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'h1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'h0, 12'(4 * i), 32'h0);
      chk("reg", {3'h0, err, rd}, {3'h0, i == 5, rstv[i]});
    end
    $display("done regs");
    for (int m = 0; m < 3; m++)
    begin
      apb(1'h1, 12'h000, 32'h8500 | 32'(m << 2));
      o = rnd();
      d = rnd();
      pa.hit(2'h3, 13'(m), o);
      pa.hit(2'h2, 13'h8, o);
      chk("rd0", aRdata, 36'h0);
      pa.hit(2'h3, 13'(m), d);
      chk("wrout", aRdata, wr_view(m, o, d));
      pa.hit(2'h2, 13'(m), o);
      chk("rdback", aRdata, d);
    end
    apb(1'h1, 12'h000, 32'hc500);
    pa.hit(2'h3, 13'h2, o);
    pa.hit(2'h2, 13'h2, o);
    chk("rom", aRdata, d);
    $display("done modes");
    apb(1'h1, 12'h000, 32'h9d01);
    d = rnd();
    pa.hit(2'h3, 13'h0, d);
    for (int i = 0; i < 4; i++)
    begin
      pb.hit(2'h2, 13'(i), rnd());
      chk("x9", bRdata, 36'(d[9 * i +: 9]));
    end
    for (int k = 0; k < 3; k++)
    begin
      pa.hit(2'h2, 13'h0, o);
      pb.hit(2'h2, 13'h1, o);
      clr(3'(1 << k));
      chk("clra", aRdata, k == 1 ? d : 36'h0);
      chk("clrb", bRdata, k == 0 ? 36'(d[17:9]) : 36'h0);
    end
    apb(1'h1, 12'h000, 32'h9d81);
    pb.hit(2'h2, 13'h1, o);
    chk("oreg0", bRdata, 36'h0);
    pb.hit(2'h2, 13'h2, o);
    chk("oreg1", bRdata, 36'(d[17:9]));
    apb(1'h1, 12'h000, 32'h29d81);
    clr(3'h0);
    chk("sclr", bRdata, 36'h0);
    $display("done widths");
    apb(1'h1, 12'h000, 32'h8503);
    apb(1'h1, 12'h004, 32'h4);
    apb(1'h1, 12'h008, 32'h3);
    apb(1'h1, 12'h00c, 32'h1);
    clr(3'h1);
    for (int i = 0; i < 4; i++)
    begin
      wd[i] = rnd();
      pa.hit(2'h3, 13'h0, wd[i]);
      chk("nfull", nearFullFlag, i == 3);
    end
    pa.hit(2'h2, 13'h0, o);
    chk("full", fullFlag, 1'h1);
    pa.hit(2'h3, 13'h0, o);
    pb.hit(2'h2, 13'h0, o);
    for (int i = 0; i < 5; i++)
    begin
      pb.hit(2'h3, 13'h0, o);
      chk("fdata", bRdata, wd[i > 3 ? 3 : i]);
      chk("eflags", {emptyFlag, nearEmptyFlag}, i == 4 ? 2'h3 : {1'h0, i == 3});
    end
    clr(3'h2);
    pb.hit(2'h2, 13'h0, o);
    pb.hit(2'h3, 13'h0, o);
    chk("again", bRdata, wd[0]);
    clr(3'h1);
    chk("aclr", {fullFlag, nearFullFlag, emptyFlag, nearEmptyFlag}, 4'h3);
    $display("done fifo");
    summarize();
  end
endmodule
bind ebrf_block_ram ebrf_monitor mon_u (.*);
`default_nettype wire
